// *** include/i2c_cond_map.vh ***
// Register map, field positions and reset values for the I2C condition
// engine with collision detection. Definitions only.
`ifndef I2C_COND_MAP_VH
`define I2C_COND_MAP_VH

// Register addresses (8-bit data, decoded on all bits of an 8-bit address)
`define ADDR_CTRL 8'h00
`define ADDR_RELOAD 8'h01
`define ADDR_STATUS 8'h02
`define ADDR_IRQ_FLAGS 8'h03
`define ADDR_IRQ_ENABLES 8'h04
`define ADDR_IRQ_PRIORITY 8'h05
`define ADDR_LINES 8'h06

// Control register request bits
`define CTRL_START 0
`define CTRL_RESTART 1
`define CTRL_STOP 2

// Event bits shared by flags, enables and priority registers
`define EV_DONE 0
`define EV_COLLISION 1
`define EV_WIDTH 2

// Reset values
`define RESET_CTRL 3'h0
`define RESET_RELOAD 7'h04
`define RESET_EVENTS 2'h0
`define RESET_COUNT 7'h00
`define COUNT_ZERO 7'h00
`define COUNT_ONE 7'h01

`endif

// *** rtl/i2c_cond_collision.v ***
// Start, Repeated Start and Stop generator for an I2C master with bus
// collision detection, register port, sticky flags and interrupts.
// Assumes open-drain bus lines resolved outside; pins are asynchronous.
`timescale 1ns/1ps
`default_nettype none
`include "i2c_cond_map.vh"

////////////////////////////////////////////////////////////////////////
// Contract
// - A Start requested while either line is already low is a collision.
// - A Start collision abandons the Start, sets the flag and idles.
// - A Start begins released; with both lines high the counter loads the reload field and counts to zero.
// - In the first Start count a low clock with data high is a collision.
// - In the first Start count a low data line reloads the counter and drives data low early, no collision.
// - Otherwise data is driven low at count end, the counter reloads, clock low then ignored, and clock is driven low at the end.
// - A Repeated Start releases data, counts the reload, releases clock and samples data once clock is high.
// - In a Repeated Start data low when the clock is first seen high is a collision.
// - With data high the counter reloads, and data falling before timeout is no collision.
// - In a Repeated Start the clock falling before timeout while data is still high is a collision.
// - With both lines high at timeout data is driven low, the counter reloads, then clock is driven low to finish.
// - A Stop drives data low, releases clock once data is low, and counts the reload once clock is high.
// - In a Stop data read low after the timeout is a collision.
// - In a Stop the clock read low after it is seen high and before data is released is a collision.
// - Any collision releases both lines and clears the request bits.
module i2c_cond_collision (
  input wire core_clk,
  input wire resetn,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_write,
  input wire reg_read,
  output reg [7:0] reg_rdata,
  input wire bus_data_line_in,
  output reg bus_data_line_out,
  output reg bus_data_line_oe_n,
  input wire bus_clock_line_in,
  output reg bus_clock_line_out,
  output reg bus_clock_line_oe_n,
  output reg irq_high,
  output reg irq_low
);

  localparam [3:0] ST_IDLE = 4'h0;
  localparam [3:0] ST_S_CHECK = 4'h1;
  localparam [3:0] ST_S_WAIT = 4'h2;
  localparam [3:0] ST_S_HOLD = 4'h3;
  localparam [3:0] ST_R_SDA = 4'h4;
  localparam [3:0] ST_R_WAIT = 4'h5;
  localparam [3:0] ST_R_SCLH = 4'h6;
  localparam [3:0] ST_R_HIGH = 4'h7;
  localparam [3:0] ST_R_HOLD = 4'h8;
  localparam [3:0] ST_P_SDAL = 4'h9;
  localparam [3:0] ST_P_SCLH = 4'ha;
  localparam [3:0] ST_P_WAIT = 4'hb;
  localparam [3:0] ST_P_DONE = 4'hc;

  //////////////////////////////////////////////////////////////////////
  // Reset release

  reg rst_meta;
  reg rst_sync;
  wire rst_n;

  always @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rst_meta <= 1'b0;
      rst_sync <= 1'b0;
    end
    else
    begin
      rst_meta <= 1'b1;
      rst_sync <= rst_meta;
    end
  end

  assign rst_n = rst_sync;

  //////////////////////////////////////////////////////////////////////
  // Pin synchronisers: three stages, a change counts once 2 and 3 agree

  reg [2:0] sda_sync;
  reg [2:0] scl_sync;
  reg sda;
  reg scl;

  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sda_sync <= 3'h7;
      scl_sync <= 3'h7;
      sda <= 1'b1;
      scl <= 1'b1;
    end
    else
    begin
      sda_sync <= {sda_sync[1:0], bus_data_line_in};
      scl_sync <= {scl_sync[1:0], bus_clock_line_in};
      if (sda_sync[1] == sda_sync[2])
        sda <= sda_sync[2];
      if (scl_sync[1] == scl_sync[2])
        scl <= scl_sync[2];
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Registers and state

  reg [2:0] ctrl;
  reg [6:0] reload;
  reg [`EV_WIDTH-1:0] irq_flags;
  reg [`EV_WIDTH-1:0] irq_enables;
  reg [`EV_WIDTH-1:0] irq_priority;
  reg [3:0] state;
  reg [6:0] baud_counter;
  reg drive_sda_low;
  reg drive_scl_low;

  reg [3:0] next_state;
  reg [6:0] next_count;
  reg next_sda_low;
  reg next_scl_low;
  reg ev_collision;
  reg ev_done;

  wire count_end;
  wire wr_ctrl;

  assign count_end = (baud_counter == `COUNT_ZERO);

  function addr_hit;
    input [7:0] addr;
    input [7:0] target;
    begin
      addr_hit = (addr == target);
    end
  endfunction

  assign wr_ctrl = reg_write && addr_hit(reg_addr, `ADDR_CTRL);

  //////////////////////////////////////////////////////////////////////
  // Condition sequencer

  always @*
  begin
    next_state = state;
    next_sda_low = drive_sda_low;
    next_scl_low = drive_scl_low;
    next_count = count_end ? `COUNT_ZERO : baud_counter - `COUNT_ONE;
    ev_collision = 1'b0;
    ev_done = 1'b0;
    case (state)
      ST_IDLE:
      begin
        next_count = `COUNT_ZERO;
        if (ctrl[`CTRL_START])
        begin
          next_sda_low = 1'b0;
          next_scl_low = 1'b0;
          next_state = ST_S_CHECK;
        end
        else if (ctrl[`CTRL_RESTART])
        begin
          next_sda_low = 1'b0;
          next_state = ST_R_SDA;
        end
        else if (ctrl[`CTRL_STOP])
        begin
          next_sda_low = 1'b1;
          next_state = ST_P_SDAL;
        end
      end
      ST_S_CHECK:
      begin
        if (!sda || !scl)
          ev_collision = 1'b1;
        else
        begin
          next_count = reload;
          next_state = ST_S_WAIT;
        end
      end
      ST_S_WAIT:
      begin
        if (!sda)
        begin
          next_sda_low = 1'b1;
          next_count = reload;
          next_state = ST_S_HOLD;
        end
        else if (!scl)
          ev_collision = 1'b1;
        else if (count_end)
        begin
          next_sda_low = 1'b1;
          next_count = reload;
          next_state = ST_S_HOLD;
        end
      end
      ST_S_HOLD:
      begin
        // Low clock here is another master's Start; ignored
        if (count_end)
        begin
          next_scl_low = 1'b1;
          ev_done = 1'b1;
          next_state = ST_IDLE;
        end
      end
      ST_R_SDA:
      begin
        if (sda)
        begin
          next_count = reload;
          next_state = ST_R_WAIT;
        end
      end
      ST_R_WAIT:
      begin
        if (count_end)
        begin
          next_scl_low = 1'b0;
          next_state = ST_R_SCLH;
        end
      end
      ST_R_SCLH:
      begin
        next_count = reload;
        if (scl)
        begin
          if (!sda)
            ev_collision = 1'b1;
          else
            next_state = ST_R_HIGH;
        end
      end
      ST_R_HIGH:
      begin
        if (!scl && sda)
          ev_collision = 1'b1;
        else if (count_end && scl && sda)
        begin
          next_sda_low = 1'b1;
          next_count = reload;
          next_state = ST_R_HOLD;
        end
        else if (!sda)
        begin
          // Another master drove data first; not a collision
          next_sda_low = 1'b1;
          next_count = reload;
          next_state = ST_R_HOLD;
        end
      end
      ST_R_HOLD:
      begin
        if (count_end)
        begin
          next_scl_low = 1'b1;
          ev_done = 1'b1;
          next_state = ST_IDLE;
        end
      end
      ST_P_SDAL:
      begin
        if (!sda)
        begin
          next_scl_low = 1'b0;
          next_state = ST_P_SCLH;
        end
      end
      ST_P_SCLH:
      begin
        next_count = reload;
        if (scl)
          next_state = ST_P_WAIT;
      end
      ST_P_WAIT:
      begin
        if (!scl)
          ev_collision = 1'b1;
        else if (count_end)
        begin
          next_sda_low = 1'b0;
          next_count = reload;
          next_state = ST_P_DONE;
        end
      end
      ST_P_DONE:
      begin
        if (count_end)
        begin
          if (!sda)
            ev_collision = 1'b1;
          else
          begin
            ev_done = 1'b1;
            next_state = ST_IDLE;
          end
        end
      end
      default:
        next_state = ST_IDLE;
    endcase
    if (ev_collision)
    begin
      next_sda_low = 1'b0;
      next_scl_low = 1'b0;
      next_count = `COUNT_ZERO;
      next_state = ST_IDLE;
    end
  end

  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state <= ST_IDLE;
      baud_counter <= `RESET_COUNT;
      drive_sda_low <= 1'b0;
      drive_scl_low <= 1'b0;
    end
    else
    begin
      state <= next_state;
      baud_counter <= next_count;
      drive_sda_low <= next_sda_low;
      drive_scl_low <= next_scl_low;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Register file

  wire [`EV_WIDTH-1:0] ev_set;
  wire [`EV_WIDTH-1:0] flag_clear;
  wire [`EV_WIDTH-1:0] pending;
  assign ev_set = {ev_collision, ev_done};
  assign flag_clear = (reg_write && addr_hit(reg_addr, `ADDR_IRQ_FLAGS)) ?
    reg_wdata[`EV_WIDTH-1:0] : `RESET_EVENTS;
  assign pending = irq_flags & irq_enables;

  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl <= `RESET_CTRL;
      reload <= `RESET_RELOAD;
      irq_flags <= `RESET_EVENTS;
      irq_enables <= `RESET_EVENTS;
      irq_priority <= `RESET_EVENTS;
      reg_rdata <= 8'h00;
      irq_high <= 1'b0;
      irq_low <= 1'b0;
    end
    else
    begin
      // Requests clear on completion or collision; software writes
      // are only taken while idle so a running condition is not bent
      if (ev_collision || ev_done)
        ctrl <= `RESET_CTRL;
      else if (wr_ctrl && state == ST_IDLE)
        ctrl <= reg_wdata[2:0];
      else if (state == ST_IDLE && next_state != ST_IDLE)
        ctrl <= ctrl;
      if (reg_write && addr_hit(reg_addr, `ADDR_RELOAD))
        reload <= reg_wdata[6:0];
      if (reg_write && addr_hit(reg_addr, `ADDR_IRQ_ENABLES))
        irq_enables <= reg_wdata[`EV_WIDTH-1:0];
      if (reg_write && addr_hit(reg_addr, `ADDR_IRQ_PRIORITY))
        irq_priority <= reg_wdata[`EV_WIDTH-1:0];
      // Set wins over a same-cycle clear
      irq_flags <= (irq_flags & ~flag_clear) | ev_set;
      irq_high <= |(pending & irq_priority);
      irq_low <= |(pending & ~irq_priority);
      reg_rdata <= 8'h00;
      if (reg_read)
      begin
        case (reg_addr)
          `ADDR_CTRL: reg_rdata <= {5'h00, ctrl};
          `ADDR_RELOAD: reg_rdata <= {1'b0, reload};
          `ADDR_STATUS: reg_rdata <= {4'h0, state};
          `ADDR_IRQ_FLAGS: reg_rdata <= {6'h00, irq_flags};
          `ADDR_IRQ_ENABLES: reg_rdata <= {6'h00, irq_enables};
          `ADDR_IRQ_PRIORITY: reg_rdata <= {6'h00, irq_priority};
          `ADDR_LINES: reg_rdata <= {4'h0, drive_scl_low, drive_sda_low,
            scl, sda};
          default: reg_rdata <= 8'h00;
        endcase
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Pin drivers: open drain, enable low while pulling the line low

  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      bus_data_line_out <= 1'b0;
      bus_clock_line_out <= 1'b0;
      bus_data_line_oe_n <= 1'b1;
      bus_clock_line_oe_n <= 1'b1;
    end
    else
    begin
      bus_data_line_out <= 1'b0;
      bus_clock_line_out <= 1'b0;
      bus_data_line_oe_n <= ~next_sda_low;
      bus_clock_line_oe_n <= ~next_scl_low;
    end
  end

endmodule
`default_nettype wire

// *** test/bus_peer.sv ***
// Other bus parties on the shared open-drain lines.
// Assumes pull-ups; the bench commands when the peer pulls a line.
`timescale 1ns/1ps
`default_nettype none
module bus_peer (
  input wire logic data_oe_n,
  input wire logic clock_oe_n,
  input wire logic hold_data_low,
  input wire logic hold_clock_low,
  input wire logic jam_on_clock,
  output logic data_line,
  output logic clock_line
);
  // Jam pulls data low the moment the clock is let go
  assign data_line = data_oe_n & ~hold_data_low & ~(jam_on_clock & clock_oe_n);
  assign clock_line = clock_oe_n & ~hold_clock_low;
endmodule
`default_nettype wire

// *** test/i2c_cond_checker_assertions.sv ***
// Port checker for the condition engine with collision detection.
// Assumes the bench keeps the reload field at 2 or more.
`timescale 1ns/1ps
`default_nettype none
module i2c_cond_checker (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic [7:0] reg_addr,
  input wire logic reg_read,
  input wire logic [7:0] reg_rdata,
  input wire logic bus_data_line_out,
  input wire logic bus_data_line_oe_n,
  input wire logic bus_clock_line_in,
  input wire logic bus_clock_line_out,
  input wire logic bus_clock_line_oe_n,
  input wire logic irq_high
);
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (!resetn);
  ////////////////////////////////////////////////////////////////////
  pin_level_a: assert property (!bus_data_line_out && !bus_clock_line_out)
    else $error("Pin output level not zero");
  read_idle_a: assert property (!$past(reg_read) |-> reg_rdata == 8'h00)
    else $error("Read data outside read slot");
  unmapped_read_a: assert property
    ($past(reg_read) && $past(reg_addr) > 8'h06 |-> reg_rdata == 8'h00)
    else $error("Unmapped read not zero");
  reload_top_a: assert property
    ($past(reg_read) && $past(reg_addr) == 8'h01 |-> !reg_rdata[7])
    else $error("Reload top bit set");
  data_before_clock_a: assert property
    ($fell(bus_clock_line_oe_n) |-> !bus_data_line_oe_n)
    else $error("Clock pulled before data");
  clock_seen_high_a: assert property
    ($fell(bus_data_line_oe_n) && bus_clock_line_oe_n
      |-> $past(bus_clock_line_in, 4))
    else $error("Data pulled after clock went low");
  start_count_a: assert property
    ($fell(bus_data_line_oe_n) && bus_clock_line_oe_n
      |=> bus_clock_line_oe_n [*2])
    else $error("Start count too short");
  stop_hold_a: assert property
    ($rose(bus_clock_line_oe_n) && !bus_data_line_oe_n
      |=> !bus_data_line_oe_n [*2])
    else $error("Stop data released too early");
  cover property ($fell(bus_clock_line_oe_n));
  cover property ($rose(irq_high));
  cover property ($rose(bus_clock_line_oe_n) && !bus_data_line_oe_n);
endmodule
bind i2c_cond_collision i2c_cond_checker chk_i (.core_clk(core_clk),
  .resetn(resetn), .reg_addr(reg_addr), .reg_read(reg_read),
  .reg_rdata(reg_rdata), .bus_data_line_out(bus_data_line_out),
  .bus_data_line_oe_n(bus_data_line_oe_n),
  .bus_clock_line_in(bus_clock_line_in),
  .bus_clock_line_out(bus_clock_line_out),
  .bus_clock_line_oe_n(bus_clock_line_oe_n), .irq_high(irq_high));
`default_nettype wire

// *** test/tb_top.sv ***
// Self-checking bench for the condition engine with collision checks.
// Assumes the peer model resolves both lines with pull-ups.
`timescale 1ns/1ps
`default_nettype none
`include "i2c_cond_map.vh"
module tb_top;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic hold_data_low = 1'b0;
  logic hold_clock_low = 1'b0;
  logic jam = 1'b0;
  logic [7:0] v;
  wire [7:0] reg_rdata;
  wire sda, scl, sda_oe_n, scl_oe_n, irq_high, irq_low;
  int error_cnt = 0;
  int checked = 0;
  always #25 core_clk = ~core_clk;
  i2c_cond_collision uut (.core_clk(core_clk), .resetn(resetn),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
    .reg_read(reg_read), .reg_rdata(reg_rdata), .bus_data_line_in(sda),
    .bus_data_line_out(), .bus_data_line_oe_n(sda_oe_n),
    .bus_clock_line_in(scl), .bus_clock_line_out(),
    .bus_clock_line_oe_n(scl_oe_n), .irq_high(irq_high), .irq_low(irq_low));
  bus_peer peer (.data_oe_n(sda_oe_n), .clock_oe_n(scl_oe_n),
    .hold_data_low(hold_data_low), .hold_clock_low(hold_clock_low),
    .jam_on_clock(jam), .data_line(sda), .clock_line(scl));
  ////////////////////////////////////////////////////////////////////
  task conclude;
    $display("Counts: checked %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge core_clk);
    reg_write <= 1'b0;
  endtask
  task rd(input logic [7:0] a);
    @(posedge core_clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge core_clk);
    reg_read <= 1'b0;
    #1 v = reg_rdata;
  endtask
  // Bounded wait on the sticky flags; the engine never stalls the port
  task poll(input logic [7:0] exp);
    int n;
    n = 0;
    v = 8'h00;
    while (v === 8'h00 && n < 100)
    begin
      rd(`ADDR_IRQ_FLAGS);
      n++;
    end
    if (v === 8'h00)
    begin
      error_cnt++;
      $display("[ERR] flags expected %h seen %h", exp, v);
      conclude;
    end
    chk("flags", exp, v);
  endtask
  task finish_cond(input logic [7:0] fl, input logic [7:0] ln);
    poll(fl);
    chk("lines", ln, {6'h00, scl_oe_n, sda_oe_n});
    chk("irq", {6'h00, fl[1], fl[0]}, {6'h00, irq_high, irq_low});
    rd(`ADDR_CTRL);
    chk("ctrl", 8'h00, v);
    rd(`ADDR_STATUS);
    chk("status", 8'h00, v);
    hold_data_low <= 1'b0;
    jam <= 1'b0;
    wr(`ADDR_IRQ_FLAGS, 8'h03);
    rd(`ADDR_IRQ_FLAGS);
    chk("irq clear", 8'h00, {6'h00, irq_high, irq_low});
  endtask
  ////////////////////////////////////////////////////////////////////
  task t_regs;
    rd(`ADDR_RELOAD);
    chk("reload reset", 8'h04, v);
    wr(`ADDR_RELOAD, 8'h05);
    rd(`ADDR_RELOAD);
    chk("reload", 8'h05, v);
    rd(8'h3c);
    chk("unmapped", 8'h00, v);
    wr(`ADDR_IRQ_ENABLES, 8'h03);
    wr(`ADDR_IRQ_PRIORITY, 8'h02);
    $display("test regs done");
  endtask
  task t_start(input logic col);
    hold_data_low <= col;
    // Let the line synchronisers settle before the request
    repeat (6) @(posedge core_clk);
    wr(`ADDR_CTRL, 8'h01);
    finish_cond(col ? 8'h02 : 8'h01, col ? 8'h03 : 8'h00);
    $display("test start done");
  endtask
  task t_stop(input logic col);
    hold_data_low <= col;
    wr(`ADDR_CTRL, 8'h04);
    finish_cond(col ? 8'h02 : 8'h01, 8'h03);
    $display("test stop done");
  endtask
  // Clean run walks through to the clock pull
  task t_restart(input logic col);
    jam <= col;
    wr(`ADDR_CTRL, 8'h02);
    finish_cond(col ? 8'h02 : 8'h01, col ? 8'h03 : 8'h00);
    $display("test restart done");
  endtask
  initial
  begin
    repeat (5) @(posedge core_clk);
    resetn <= 1'b1;
    repeat (5) @(posedge core_clk);
    t_regs;
    t_start(1'b0);
    t_stop(1'b0);
    t_start(1'b1);
    t_start(1'b0);
    t_restart(1'b0);
    t_restart(1'b1);
    t_start(1'b0);
    t_stop(1'b1);
    conclude;
  end
endmodule
`default_nettype wire
